// File: shared/cqf_pkg.sv
// Package for the command queue front end: offsets, fields, opcodes, types
package cqf_pkg;

    // Register byte offsets
    localparam logic [7:0] CQF_OFF_CTRL = 8'h00;
    localparam logic [7:0] CQF_OFF_STATUS = 8'h04;
    localparam logic [7:0] CQF_OFF_BASE = 8'h08;
    localparam logic [7:0] CQF_OFF_PROD = 8'h0c;
    localparam logic [7:0] CQF_OFF_CONS = 8'h10;
    localparam logic [7:0] CQF_OFF_ERRCLR = 8'h14;

    // Control fields
    localparam int CQF_CTRL_EN_BIT = 0;
    localparam int CQF_CTRL_SEV_BIT = 1;
    localparam int CQF_CTRL_RSVCHK_BIT = 2;
    localparam logic [31:0] CQF_CTRL_RESET = 32'h0000_0000;

    // Status fields
    localparam int CQF_ST_ENACK_BIT = 0;
    localparam int CQF_ST_ERRV_BIT = 1;
    localparam int CQF_ST_BUSY_BIT = 2;
    localparam int CQF_ST_CODE_LSB = 8;

    // Queue geometry
    localparam int CQF_LOG2_ENTRIES = 4;
    localparam int CQF_IDX_W = CQF_LOG2_ENTRIES + 1;
    localparam int CQF_ENTRY_BYTES = 16;
    localparam int CQF_ENTRY_SHIFT = 4;
    localparam int CQF_ENTRY_WORDS = 4;
    localparam int CQF_OPC_W = 8;
    localparam logic [31:0] CQF_BASE_RESET = 32'h0000_0000;

    // Error codes
    localparam logic [1:0] CQF_ERR_NONE = 2'h0;
    localparam logic [1:0] CQF_ERR_ILL = 2'h1;
    localparam logic [1:0] CQF_ERR_ABT = 2'h2;

    // Opcodes with special handling
    localparam logic [7:0] CQF_OP_PREF_CFG = 8'h01;
    localparam logic [7:0] CQF_OP_PREF_ADDR = 8'h02;
    localparam logic [7:0] CQF_OP_CFGI_RANGE = 8'h04;
    localparam logic [7:0] CQF_OP_SYNC = 8'h46;
    localparam logic [7:0] CQF_OP_IMPDEF_LO = 8'h80;
    localparam logic [7:0] CQF_OP_IMPDEF_HI = 8'h8f;

    // Entry word as fetched
    typedef struct packed {
        logic [31:0] data;
        logic abort;
    } cqf_rword_t;

    // Decoded command handed to the back end
    typedef struct packed {
        logic [CQF_OPC_W-1:0] opcode;
        logic [127:0] entry;
        logic is_sync;
    } cqf_cmd_t;

endpackage

// File: rtl/cqf_decode.sv
// Opcode decoder: defined set and reserved field check
`timescale 1ns/1ps
module cqf_decode
    import cqf_pkg::*;
(
    // Entry in
    input wire logic [127:0] entry,
    input wire logic rsv_check,
    // Result
    output logic illegal,
    output logic is_sync
);

    // Defined opcode table
    function automatic logic op_defined(input logic [7:0] op);
        unique case (op) inside
            [8'h01:8'h07], [8'h10:8'h13], 8'h18, 8'h1a, [8'h20:8'h23],
            8'h28, 8'h2a, 8'h30, 8'h40, 8'h41, [8'h44:8'h46],
            [8'h50:8'h53], 8'h58, 8'h5a, 8'h60: op_defined = 1'b1;
            default: op_defined = 1'b0;
        endcase
    endfunction

    logic [7:0] op;
    logic bad_param;
    logic rsv_nz;

    assign op = entry[CQF_OPC_W-1:0];
    assign is_sync = (op == CQF_OP_SYNC);
    // Secure flag bit set on non-secure queue is invalid for prefetch
    assign bad_param = ((op == CQF_OP_PREF_CFG) || (op == CQF_OP_PREF_ADDR)) && entry[10];
    // Bits 9..8 and 31..11 of word 0 unused in this front end
    assign rsv_nz = rsv_check && ((entry[9:8] != 2'h0) || (entry[31:11] != 21'h0));
    // Implementation defined range is not implemented: illegal too
    assign illegal = !op_defined(op) || bad_param || rsv_nz;

endmodule

// File: rtl/cqf_frontend.sv
// Command queue front end: AHB-Lite registers, entry fetch, decode, errors
// Overview of operation
// - Each entry is sixteen bytes, little-endian, for both producer and unit.
// - The low eight bits of each entry are the opcode.
// - Decoder recognises the defined opcode set.
// - Reserved opcodes, including 0x00 and 0x90-0xFF, raise illegal-command.
// - No entry at or beyond the producer index is executed.
// - A producer index write alone starts processing.
// - Process only when non-empty, enabled and no error active.
// - Keep processing until empty, error or disabled.
// - With wake support set, pulse wake event when a seen-full queue is no longer full.
// - Defined opcode with invalid parameters raises illegal-command.
// - Optional check of reserved fields; non-zero raises illegal-command.
// - Illegal-command wins over an ignored command.
// - External abort on queue read raises fetch abort.
// - First error stops consumption; consumer index stays on failing command.
// - A command is consumed once the consumer index passes it.
// - Sync completes after all earlier commands; earlier ones never wait.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module cqf_frontend
    import cqf_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Memory read port for queue fetch
    output logic MEM_REQ,
    output logic [31:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire cqf_rword_t MEM_RDATA,
    // Command issue to back end
    output logic CMD_VALID,
    output cqf_cmd_t CMD,
    input wire logic CMD_READY,
    input wire logic CMD_IDLE,
    // Wake event
    output logic WAKE_EVENT
);

    typedef enum logic [2:0] {
        CQF_IDLE,
        CQF_FETCH,
        CQF_DECODE,
        CQF_ISSUE,
        CQF_DRAIN
    } cqf_state_t;

    cqf_state_t state;
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [CQF_IDX_W-1:0] prod;
    logic [CQF_IDX_W-1:0] cons;
    logic [1:0] err_code;
    logic [127:0] entry;
    logic [1:0] word_idx;
    logic seen_full;
    logic dec_illegal;
    logic dec_sync;

    // Bus address phase capture
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;

    logic q_empty;
    logic q_full;
    logic err_active;
    logic can_run;
    logic wr_en;

    // Index helpers
    function automatic logic idx_full(input logic [CQF_IDX_W-1:0] p,
                                      input logic [CQF_IDX_W-1:0] c);
        idx_full = (p[CQF_IDX_W-1] != c[CQF_IDX_W-1]) &&
                   (p[CQF_IDX_W-2:0] == c[CQF_IDX_W-2:0]);
    endfunction

    assign q_empty = (prod == cons);
    assign q_full = idx_full(prod, cons);
    assign err_active = (err_code != CQF_ERR_NONE);
    assign can_run = !q_empty && ctrl[CQF_CTRL_EN_BIT] && !err_active;

    cqf_decode u_decode (
        .entry(entry),
        .rsv_check(ctrl[CQF_CTRL_RSVCHK_BIT]),
        .illegal(dec_illegal),
        .is_sync(dec_sync)
    );

    // Bus: zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign wr_en = ph_valid && ph_write;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 8'h00;
        end else if (HREADY) begin
            ph_valid <= HSEL && HTRANS[1];
            ph_write <= HWRITE;
            ph_addr <= HADDR[7:0];
        end
    end

    // Read data
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
            unique case (HADDR[7:0])
                CQF_OFF_CTRL: HRDATA <= ctrl;
                CQF_OFF_STATUS: HRDATA <= {22'h0, err_code, 5'h0,
                    (state != CQF_IDLE), err_active, ctrl[CQF_CTRL_EN_BIT]};
                CQF_OFF_BASE: HRDATA <= base;
                CQF_OFF_PROD: HRDATA <= {{(32-CQF_IDX_W){1'b0}}, prod};
                CQF_OFF_CONS: HRDATA <= {{(32-CQF_IDX_W){1'b0}}, cons};
                default: HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Control, base, producer index
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ctrl <= CQF_CTRL_RESET;
            base <= CQF_BASE_RESET;
            prod <= '0;
        end else if (wr_en) begin
            unique case (ph_addr)
                CQF_OFF_CTRL: ctrl <= {29'h0, HWDATA[2:0]};
                CQF_OFF_BASE: base <= {HWDATA[31:CQF_ENTRY_SHIFT], 4'h0};
                CQF_OFF_PROD: prod <= HWDATA[CQF_IDX_W-1:0];
                default: ;
            endcase
        end
    end

    // Error register; new error wins over clear
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            err_code <= CQF_ERR_NONE;
        end else if (state == CQF_FETCH && MEM_ACK && MEM_RDATA.abort) begin
            err_code <= CQF_ERR_ABT;
        end else if (state == CQF_DECODE && dec_illegal) begin
            err_code <= CQF_ERR_ILL;
        end else if (wr_en && ph_addr == CQF_OFF_ERRCLR && HWDATA[0]) begin
            err_code <= CQF_ERR_NONE;
        end
    end

    // Fetch and issue sequencer
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state <= CQF_IDLE;
            word_idx <= 2'h0;
            entry <= '0;
        end else begin
            unique case (state)
                CQF_IDLE: begin
                    word_idx <= 2'h0;
                    if (can_run) begin
                        state <= CQF_FETCH;
                    end
                end
                CQF_FETCH: begin
                    if (MEM_ACK) begin
                        if (MEM_RDATA.abort) begin
                            state <= CQF_IDLE;
                        end else begin
                            // Little-endian: word n holds bytes 4n..4n+3
                            entry[word_idx*32 +: 32] <= MEM_RDATA.data;
                            word_idx <= word_idx + 2'h1;
                            if (word_idx == 2'(CQF_ENTRY_WORDS - 1)) begin
                                state <= CQF_DECODE;
                            end
                        end
                    end
                end
                CQF_DECODE: begin
                    if (dec_illegal) begin
                        state <= CQF_IDLE;
                    end else if (dec_sync) begin
                        state <= CQF_DRAIN;
                    end else begin
                        state <= CQF_ISSUE;
                    end
                end
                CQF_DRAIN: begin
                    if (CMD_IDLE) begin
                        state <= CQF_ISSUE;
                    end
                end
                CQF_ISSUE: begin
                    if (CMD_READY) begin
                        state <= CQF_IDLE;
                    end
                end
                default: state <= CQF_IDLE;
            endcase
        end
    end

    // Consumer index advances only when the command is handed on
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            cons <= '0;
        end else if (state == CQF_ISSUE && CMD_READY) begin
            cons <= CQF_IDX_W'(cons + 1'b1);
        end
    end

    // Memory request: base + wrapped index * 16 + word offset
    assign MEM_REQ = (state == CQF_FETCH);
    assign MEM_ADDR = base + {{(32-CQF_LOG2_ENTRIES-CQF_ENTRY_SHIFT){1'b0}},
        cons[CQF_IDX_W-2:0], word_idx, 2'h0};

    // Command out
    assign CMD_VALID = (state == CQF_ISSUE);
    assign CMD = '{opcode: entry[CQF_OPC_W-1:0], entry: entry, is_sync: dec_sync};

    // Full seen whenever the queue is full, then wake once it is no longer full if the ctrl SEV bit is set
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            seen_full <= 1'b0;
            WAKE_EVENT <= 1'b0;
        end else begin
            WAKE_EVENT <= 1'b0;
            if (seen_full && !q_full) begin
                seen_full <= 1'b0;
                WAKE_EVENT <= ctrl[CQF_CTRL_SEV_BIT];
            end else if (q_full) begin
                seen_full <= 1'b1;
            end
        end
    end

endmodule

// File: tb/cqf_frontend_chk.sv
// Checker for the command queue front end ports
`timescale 1ns/1ps
module cqf_frontend_chk
    import cqf_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // Watched ports
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic MEM_ACK,
    input wire cqf_rword_t MEM_RDATA,
    input wire logic CMD_VALID,
    input wire cqf_cmd_t CMD,
    input wire logic CMD_READY,
    input wire logic CMD_IDLE,
    input wire logic WAKE_EVENT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus stalled or not okay");
    a_reset_quiet: assert property ($rose(RESET_N) |-> !MEM_REQ && !CMD_VALID && !WAKE_EVENT)
        else $error("outputs active after reset");
    a_entry_start: assert property ($rose(MEM_REQ) |-> MEM_ADDR[3:0] == 4'h0)
        else $error("fetch not on entry start");
    a_word_step: assert property (MEM_REQ && MEM_ACK && !MEM_RDATA.abort
        && MEM_ADDR[3:2] != 2'h3 |=> MEM_REQ && MEM_ADDR == $past(MEM_ADDR) + 32'h4)
        else $error("fetch address did not step");
    a_abort_stop: assert property (MEM_REQ && MEM_ACK && MEM_RDATA.abort
        |=> (!MEM_REQ && !CMD_VALID) [*3]) else $error("went on after abort");
    a_cmd_hold: assert property (CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD))
        else $error("command dropped before taken");
    a_opcode_low: assert property (CMD_VALID |-> CMD.opcode == CMD.entry[7:0]
        && CMD.is_sync == (CMD.opcode == CQF_OP_SYNC)) else $error("opcode field wrong");
    a_no_reserved: assert property (CMD_VALID |->
        CMD.opcode != 8'h00 && CMD.opcode < 8'h80) else $error("reserved opcode issued");
    a_sync_idle: assert property ($rose(CMD_VALID) && CMD.is_sync |->
        CMD_IDLE || $past(CMD_IDLE)) else $error("sync issued while busy");
    a_wake_pulse: assert property (WAKE_EVENT |=> !WAKE_EVENT) else $error("wake too long");
    c_wake: cover property (WAKE_EVENT);
    c_abort: cover property (MEM_ACK && MEM_RDATA.abort);
    c_sync: cover property (CMD_VALID && CMD_READY && CMD.is_sync);
endmodule

bind cqf_frontend cqf_frontend_chk u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
    .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .CMD_IDLE(CMD_IDLE), .WAKE_EVENT(WAKE_EVENT));

// File: tb/cqf_mem_model.sv
// Queue memory model, prompt or slow, with abort on a chosen address
`timescale 1ns/1ps
module cqf_mem_model
    import cqf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fetch port
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack = 1'b0,
    output cqf_rword_t mem_rdata = '0
);
    logic [31:0] mem [64];
    logic [31:0] abort_addr = '1;
    int delay = 0;
    int waited = 0;
    always @(posedge clk) begin
        if (!rst_n || mem_req !== 1'b1 || mem_ack) begin
            waited <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (waited < delay) begin
            waited <= waited + 1;
        end else begin
            mem_ack <= 1'b1;
            mem_rdata.data <= mem[mem_addr[7:2]];
            mem_rdata.abort <= mem_addr == abort_addr || mem_addr[31:8] != 24'h2;
        end
    end
endmodule

// File: tb/cqf_frontend_bench.sv
// Bench for the command queue front end
`timescale 1ns/1ps
module cqf_frontend_bench;
    import cqf_pkg::*;
    typedef struct packed {logic [31:0] w0; logic ill;} cqf_row_t;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic CMD_READY = 1'b0;
    logic CMD_IDLE = 1'b1;
    logic [31:0] HADDR = '0;
    logic [31:0] HWDATA = '0;
    logic [1:0] HTRANS = '0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HRDATA, MEM_ADDR, rd;
    logic HREADYOUT, HRESP, MEM_REQ, MEM_ACK, CMD_VALID, WAKE_EVENT;
    cqf_rword_t MEM_RDATA;
    cqf_cmd_t CMD;
    logic [4:0] prod = '0;
    logic [4:0] cons = '0;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int wakes = 0;
    cqf_row_t rows [5] = '{'{32'h0000_0401, 1'h1}, '{32'h0000_0402, 1'h1},
        '{32'h0000_0103, 1'h1}, '{32'h8000_0005, 1'h1}, '{32'h0000_0002, 1'h0}};
    always #10 REF_CLK = ~REF_CLK;
    cqf_frontend DUT (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEM_REQ(MEM_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .CMD_VALID(CMD_VALID),
        .CMD(CMD), .CMD_READY(CMD_READY), .CMD_IDLE(CMD_IDLE), .WAKE_EVENT(WAKE_EVENT));
    cqf_mem_model u_mem (.clk(REF_CLK), .rst_n(RESET_N), .mem_req(MEM_REQ),
        .mem_addr(MEM_ADDR), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cycles++;
        if (WAKE_EVENT === 1'b1) wakes++;
        if (cycles == 80000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd & m);
    endtask
    function automatic logic [127:0] ent(input logic [3:0] s, input logic [31:0] w0);
        return {8'hc3, s, 20'h0, 8'h5a, s, 20'h1, 8'ha5, s, 20'h2, w0};
    endfunction
    function automatic logic legal(input logic [7:0] o);
        return o inside {[8'h01:8'h07], [8'h10:8'h13], 8'h18, 8'h1a, [8'h20:8'h23], 8'h28,
            8'h2a, 8'h30, 8'h40, 8'h41, [8'h44:8'h46], [8'h50:8'h53], 8'h58, 8'h5a, 8'h60};
    endfunction
    task automatic sub(input logic [31:0] w0);
        logic [127:0] e;
        e = ent(prod[3:0], w0);
        for (int n = 0; n < 4; n++) u_mem.mem[{prod[3:0], 2'(n)}] = e[32*n +: 32];
        prod = prod + 5'h1;
        bus(1'b1, CQF_OFF_PROD, {27'h0, prod});
    endtask
    task automatic take(input logic x, input logic [31:0] w0);
        int n;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (CMD_VALID !== 1'b1 && n < 40);
        chk("valid", x, CMD_VALID);
        if (CMD_VALID === 1'b1) begin
            chk("opcode", w0[7:0], CMD.opcode);
            chk("entry", ent(cons[3:0], w0), CMD.entry);
            CMD_READY <= 1'b1;
            @(posedge REF_CLK);
            CMD_READY <= 1'b0;
            cons = cons + 5'h1;
        end
    endtask
    task automatic run(input logic [31:0] w0, input logic ill);
        sub(w0);
        take(!ill, w0);
        rdc("err", CQF_OFF_STATUS, {22'h0, ill ? CQF_ERR_ILL : CQF_ERR_NONE, 6'h0, ill, 1'h0},
            32'h0000_0302);
        rdc("cons", CQF_OFF_CONS, {27'h0, cons}, 32'h1f);
        if (ill) begin
            prod = prod - 5'h1;
            sub(32'h0000_0003);
            bus(1'b1, CQF_OFF_ERRCLR, 32'h1);
            take(1'h1, 32'h0000_0003);
        end
    endtask
    task automatic reset();
        RESET_N <= 1'b0;
        repeat (5) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        prod = '0;
        cons = '0;
        rdc("ctrl", CQF_OFF_CTRL, CQF_CTRL_RESET, '1);
        rdc("cons", CQF_OFF_CONS, 32'h0, '1);
        rdc("status", CQF_OFF_STATUS, 32'h0, 32'h0000_0307);
    endtask
    initial begin
        reset();
        bus(1'b1, CQF_OFF_BASE, 32'h0000_0200);
        rdc("base", CQF_OFF_BASE, 32'h0000_0200, '1);
        bus(1'b1, CQF_OFF_CTRL, 32'h0000_0005);
        foreach (rows[i]) run(rows[i].w0, rows[i].ill);
        for (int op = 0; op < 256; op++) run({24'h0, 8'(op)}, !legal(8'(op)));
        u_mem.abort_addr = {24'h2, cons[3:0], 4'h8};
        sub(32'h0000_0010);
        take(1'h0, 32'h0);
        rdc("abort", CQF_OFF_STATUS, {22'h0, CQF_ERR_ABT, 8'h2}, 32'h0000_0302);
        rdc("cons", CQF_OFF_CONS, {27'h0, cons}, 32'h1f);
        u_mem.abort_addr = '1;
        bus(1'b1, CQF_OFF_ERRCLR, 32'h1);
        take(1'h1, 32'h0000_0010);
        CMD_IDLE <= 1'b0;
        sub(32'h0000_0046);
        take(1'h0, 32'h0);
        rdc("busy", CQF_OFF_STATUS, 32'h0000_0005, 32'h0000_0307);
        CMD_IDLE <= 1'b1;
        take(1'h1, 32'h0000_0046);
        bus(1'b1, CQF_OFF_CTRL, 32'h0000_0002);
        u_mem.delay = 3;
        wakes = 0;
        rdc("space", CQF_OFF_CONS, {27'h0, cons}, 32'h1f);
        repeat (16) sub(32'h0000_0120);
        rdc("full", CQF_OFF_CONS, {27'h0, cons}, 32'h1f);
        take(1'h0, 32'h0);
        bus(1'b1, CQF_OFF_CTRL, 32'h0000_0003);
        repeat (16) take(1'h1, 32'h0000_0120);
        take(1'h0, 32'h0);
        chk("wakes", 1, wakes);
        bus(1'b1, 8'h3c, 32'hffff_ffff);
        rdc("unmapped", 8'h3c, 32'h0, '1);
        bus(1'b1, CQF_OFF_CONS, 32'h0000_001f);
        rdc("cons ro", CQF_OFF_CONS, {27'h0, cons}, 32'h1f);
        reset();
        end_of_test();
    end
endmodule
